// file: design/eac_ctrl.sv
// Data EEPROM access control: control, address and data registers, write timer, halts
`timescale 1ns/10ps
module eac_ctrl
    import eac_pkg::*;
#(
    parameter int WRITE_TICKS = OSC_CYCLES
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ctrl_we,
    input  wire logic [7:0]        ctrl_wdata,
    input  wire logic              addr_lo_we,
    input  wire logic              addr_hi_we,
    input  wire logic [7:0]        addr_wdata,
    input  wire logic              data_we,
    input  wire logic [7:0]        data_wdata,
    input  wire logic              global_irq_en,
    input  wire logic              flash_selfprog_active,
    output logic [7:0]             nvm_control,
    output logic [15:0]            nvm_byte_address,
    output logic [DATA_W-1:0]      nvm_byte_data,
    output logic                   ready_irq,
    output logic                   cpu_halt,
    output eac_mem_req_t           mem_req,
    output logic                   mem_req_valid,
    input  wire logic [DATA_W-1:0] mem_rdata
);
    localparam int TW = $clog2(WRITE_TICKS + 1);
    localparam int AW = $clog2(ARM_CYCLES + 1);
    localparam int HW = $clog2(READ_HALT + 1);

    if (WRITE_TICKS < 1) begin : g_bad_ticks
        $error("WRITE_TICKS must be positive");
    end

    logic              rie_r, rie_nxt;
    // Power-up value only; rst leaves the write engine alone
    logic              busy_r = 1'b0;
    logic              busy_nxt;
    logic [AW-1:0]     arm_cnt_r, arm_cnt_nxt;
    logic [TW-1:0]     wtime_r = '0;
    logic [TW-1:0]     wtime_nxt;
    logic [HW-1:0]     halt_r, halt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic              req_v_r, req_v_nxt;
    eac_mem_req_t      req_r, req_nxt;
    logic              tick;
    logic              arm;
    logic              start_wr;
    logic              do_read;

    eac_osc_tick #(.DIV(OSC_DIV)) u_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick)
    );

    // Strobe decode; no write may start while reset is held
    assign arm      = (arm_cnt_r != '0);
    assign start_wr = ctrl_we && ctrl_wdata[BIT_WSTROBE] && arm && !busy_r
                      && !flash_selfprog_active && !rst;
    assign do_read  = ctrl_we && ctrl_wdata[BIT_READ] && !busy_r;

    // Next values of arm window, write timer, halts and registers
    always_comb begin
        rie_nxt     = rie_r;
        busy_nxt    = busy_r;
        arm_cnt_nxt = arm_cnt_r;
        wtime_nxt   = wtime_r;
        halt_nxt    = (halt_r != '0) ? halt_r - 1'b1 : halt_r;
        addr_nxt    = addr_r;
        data_nxt    = data_r;
        req_v_nxt   = 1'b0;
        req_nxt     = req_r;
        if (arm) begin
            arm_cnt_nxt = arm_cnt_r - 1'b1;
        end
        if (ctrl_we) begin
            rie_nxt = ctrl_wdata[BIT_RIE];
            if (ctrl_wdata[BIT_ARM] && !ctrl_wdata[BIT_WSTROBE]) begin
                arm_cnt_nxt = AW'(ARM_CYCLES);
            end
        end
        if (busy_r && tick) begin
            if (wtime_r == TW'(1)) begin
                busy_nxt = 1'b0;
            end
            wtime_nxt = wtime_r - 1'b1;
        end
        if (start_wr) begin
            busy_nxt    = 1'b1;
            wtime_nxt   = TW'(WRITE_TICKS);
            arm_cnt_nxt = '0;
            halt_nxt    = HW'(WRITE_HALT);
            req_v_nxt   = 1'b1;
            req_nxt     = '{wr: 1'b1, addr: addr_r, data: data_r};
        end else if (do_read) begin
            data_nxt = mem_rdata;
            halt_nxt = HW'(READ_HALT);
        end
        if (!busy_r) begin
            if (addr_lo_we) addr_nxt[7:0] = addr_wdata;
            if (addr_hi_we) addr_nxt[ADDR_W-1:8] = addr_wdata[ADDR_W-9:0];
        end
        if (data_we) data_nxt = data_wdata;
    end

    // Write timer is not reset so a started write completes across reset
    always_ff @(posedge ref_clk) begin
        busy_r  <= busy_nxt;
        wtime_r <= wtime_nxt;
        addr_r  <= addr_nxt;
        data_r  <= data_nxt;
        req_r   <= req_nxt;
        if (rst) begin
            rie_r     <= 1'b0;
            arm_cnt_r <= '0;
            halt_r    <= '0;
            req_v_r   <= 1'b0;
        end else begin
            rie_r     <= rie_nxt;
            arm_cnt_r <= arm_cnt_nxt;
            halt_r    <= halt_nxt;
            req_v_r   <= req_v_nxt;
        end
    end

    // Control register read-back
    always_comb begin
        nvm_control              = 8'h00 & CTRL_RSVD_MASK;
        nvm_control[BIT_RIE]     = rie_r;
        nvm_control[BIT_ARM]     = arm;
        nvm_control[BIT_WSTROBE] = busy_r;
        nvm_control[BIT_READ]    = 1'b0;
    end

    assign nvm_byte_address = {5'h00, addr_r};
    assign nvm_byte_data    = data_r;
    assign ready_irq        = rie_r && global_irq_en && !busy_r;
    assign cpu_halt         = (halt_r != '0);
    assign mem_req          = req_r;
    assign mem_req_valid    = req_v_r;

    // Rule checks
    AST_RSVD_ZERO: assert property (@(posedge ref_clk) (nvm_control & CTRL_RSVD_MASK) == 8'h00)
        else $error("Reserved control bits nonzero");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (rst)
        ready_irq == (rie_r && global_irq_en && !nvm_control[BIT_WSTROBE]))
        else $error("Ready interrupt wrong");
    AST_IRQ_ON_DONE: assert property (@(posedge ref_clk) disable iff (rst)
        ($fell(busy_r) && rie_r && global_irq_en) |-> ready_irq)
        else $error("Ready interrupt missing after write");
    AST_START: assert property (@(posedge ref_clk) disable iff (rst)
        start_wr |=> busy_r && mem_req_valid && mem_req.wr)
        else $error("Write not started");
    AST_ARM_SET: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_we && ctrl_wdata[BIT_ARM] && !ctrl_wdata[BIT_WSTROBE]) |=> arm)
        else $error("Arm not set");
    AST_SINGLE_REQ: assert property (@(posedge ref_clk) disable iff (rst)
        mem_req_valid |=> !mem_req_valid)
        else $error("Write request longer than one cycle");
    AST_NOARM: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_we && ctrl_wdata[BIT_WSTROBE] && !arm && !busy_r) |=> !busy_r)
        else $error("Write without arm");
    AST_ARM_TIMEOUT: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_we && ctrl_wdata[BIT_ARM] && !ctrl_wdata[BIT_WSTROBE]) ##1 !ctrl_we [*4] |=> !arm)
        else $error("Arm did not time out");
    AST_WR_DONE: assert property (@(posedge ref_clk) disable iff (rst)
        (busy_r && tick && wtime_r == TW'(1)) |=> !busy_r)
        else $error("Write did not finish on last tick");
    AST_WR_HOLD: assert property (@(posedge ref_clk)
        (busy_r && !(tick && wtime_r == TW'(1))) |=> busy_r)
        else $error("Write ended early");
    AST_WR_HALT: assert property (@(posedge ref_clk) disable iff (rst)
        start_wr |=> cpu_halt [*2] ##1 !cpu_halt)
        else $error("Write halt not two cycles");
    AST_NO_HALT_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
        (!start_wr && !do_read && !cpu_halt) |=> !cpu_halt)
        else $error("Halt without access");
    AST_RD_DATA: assert property (@(posedge ref_clk) disable iff (rst)
        (do_read && !data_we) |=> nvm_byte_data == $past(mem_rdata))
        else $error("Read data not loaded");
    AST_RD_HALT: assert property (@(posedge ref_clk) disable iff (rst)
        (do_read && !start_wr) |=> cpu_halt [*4] ##1 !cpu_halt)
        else $error("Read halt not four cycles");
    AST_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        busy_r |=> $stable(addr_r))
        else $error("Address changed during write");
    AST_RD_REFUSED: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_we && ctrl_wdata[BIT_READ] && busy_r && !data_we) |=> $stable(data_r))
        else $error("Read taken during write");
    AST_FLASH: assert property (@(posedge ref_clk) disable iff (rst)
        flash_selfprog_active |=> !mem_req_valid)
        else $error("Write during flash programming");
    AST_ADDR_HI_ZERO: assert property (@(posedge ref_clk) nvm_byte_address[15:ADDR_W] == '0)
        else $error("Upper address bits nonzero");
    AST_REQ_CONTENT: assert property (@(posedge ref_clk) disable iff (rst)
        start_wr |=> mem_req.addr == $past(addr_r) && mem_req.data == $past(data_r))
        else $error("Write request carries wrong address or data");

    // Scenario coverage
    COV_WRITE: cover property (@(posedge ref_clk) disable iff (rst) start_wr);
    COV_READ:  cover property (@(posedge ref_clk) disable iff (rst) do_read);
    COV_DONE:  cover property (@(posedge ref_clk) disable iff (rst) $fell(busy_r));
    COV_IRQ:   cover property (@(posedge ref_clk) disable iff (rst) $rose(ready_irq));
    COV_RST_BUSY: cover property (@(posedge ref_clk) rst && busy_r);
endmodule : eac_ctrl

// file: design/eac_pkg.sv
// Package with register layout and timing constants for the data EEPROM access control
package eac_pkg;
    localparam int          ADDR_W          = 11;
    localparam int          DATA_W          = 8;
    localparam int          BIT_READ        = 0;
    localparam int          BIT_WSTROBE     = 1;
    localparam int          BIT_ARM         = 2;
    localparam int          BIT_RIE         = 3;
    localparam logic [7:0]  CTRL_RSVD_MASK  = 8'hf0;
    localparam int          ARM_CYCLES      = 4;
    localparam int          WRITE_HALT      = 2;
    localparam int          READ_HALT       = 4;
    localparam int          OSC_CYCLES      = 8448;
    localparam int          OSC_KHZ         = 1000;
    localparam int          CLK_KHZ         = 50000;
    localparam int          WRITE_CLK_CYCLES = OSC_CYCLES * (CLK_KHZ / OSC_KHZ);
    localparam int          OSC_DIV         = CLK_KHZ / OSC_KHZ;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } eac_mem_req_t;
endpackage : eac_pkg

// file: design/eac_osc_tick.sv
// Divider producing a 1 MHz enable pulse from ref_clk
`timescale 1ns/10ps
module eac_osc_tick
    import eac_pkg::*;
#(
    parameter int DIV = OSC_DIV
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    output logic      tick
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    if (DIV < 2) begin : g_bad_div
        $error("DIV must be at least 2");
    end

    always_comb begin
        cnt_nxt = (cnt_r == CW'(DIV - 1)) ? '0 : cnt_r + 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick = (cnt_r == CW'(DIV - 1));
endmodule : eac_osc_tick

// file: sim/eac_ctrl_bench.sv
// Self-checking bench for the data EEPROM access control block
`timescale 1ns/10ps
module eac_ctrl_bench;
    import eac_pkg::*;
    localparam int     TK  = 4;
    localparam int     LIM = (TK + 1) * OSC_DIV + 20;
    logic              ref_clk = 1'b0;
    logic              rst = 1'b1;
    logic              ctrl_we = 1'b0, addr_lo_we = 1'b0, addr_hi_we = 1'b0, data_we = 1'b0;
    logic [7:0]        ctrl_wdata = 8'h00, addr_wdata = 8'h00, data_wdata = 8'h00;
    logic              global_irq_en = 1'b0, flash_selfprog_active = 1'b0, gie = 1'b0;
    logic [7:0]        nvm_control;
    logic [15:0]       nvm_byte_address;
    logic [DATA_W-1:0] nvm_byte_data;
    logic              ready_irq, cpu_halt, mem_req_valid, rie;
    eac_mem_req_t      mem_req;
    logic [DATA_W-1:0] mem [2048];
    logic [10:0]       a;
    logic [7:0]        d;
    int                error_cnt = 0, compares = 0, n = 0;
    int                seed = 32'h1df4fd05;

    eac_ctrl #(.WRITE_TICKS(TK)) u_eac_ctrl (
        .ref_clk(ref_clk), .rst(rst), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
        .addr_lo_we(addr_lo_we), .addr_hi_we(addr_hi_we), .addr_wdata(addr_wdata),
        .data_we(data_we), .data_wdata(data_wdata), .global_irq_en(global_irq_en),
        .flash_selfprog_active(flash_selfprog_active), .nvm_control(nvm_control),
        .nvm_byte_address(nvm_byte_address), .nvm_byte_data(nvm_byte_data), .ready_irq(ready_irq),
        .cpu_halt(cpu_halt), .mem_req(mem_req), .mem_req_valid(mem_req_valid),
        .mem_rdata(mem[nvm_byte_address[10:0]]));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // Byte array behind the block
    always @(posedge ref_clk) begin
        if (mem_req_valid === 1'b1 && mem_req.wr === 1'b1)
            mem[mem_req.addr] <= mem_req.data;
    end

    task automatic summarize();
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One cycle of register traffic: 0 idle, 1 control, 2 addr low, 3 addr high, 4 data
    task automatic put(input int k, input logic [7:0] v);
        ctrl_we    = (k == 1);
        addr_lo_we = (k == 2);
        addr_hi_we = (k == 3);
        data_we    = (k == 4);
        ctrl_wdata = v;
        addr_wdata = v;
        data_wdata = v;
        @(negedge ref_clk);
    endtask : put

    task automatic nvm_write(input logic [10:0] wa, input logic [7:0] wd, input logic ok);
        global_irq_en = 1'b0;
        put(2, wa[7:0]);
        put(3, {5'h00, wa[10:8]});
        put(4, wd);
        put(1, {4'h0, rie, 3'h4});
        put(1, {4'h0, rie, 3'h2});
        global_irq_en = gie;
        chk(mem_req_valid, ok);
        chk(nvm_control[1], ok);
        chk(cpu_halt, ok);
        if (ok) chk(mem_req, {1'b1, wa, wd});
        put(0, 8'h00);
        chk(cpu_halt, ok);
        chk(ready_irq, 1'b0);
        put(0, 8'h00);
        chk(cpu_halt, 1'b0);
    endtask : nvm_write

    task automatic wait_done();
        n = 0;
        while (nvm_control[1] !== 1'b0 && n < LIM) begin
            put(0, 8'h00);
            n++;
        end
        chk(n > (TK - 1) * OSC_DIV - 5 && n < LIM, 1'b1);
        chk(ready_irq, rie & global_irq_en);
    endtask : wait_done

    task automatic nvm_read(input logic [10:0] ra, input logic [7:0] exp);
        put(2, ra[7:0]);
        put(3, {5'h00, ra[10:8]});
        put(1, {4'h0, rie, 3'h1});
        repeat (4) begin
            chk(cpu_halt, 1'b1);
            put(0, 8'h00);
        end
        chk(cpu_halt, 1'b0);
        chk(nvm_byte_data, exp);
        chk(nvm_byte_address, {5'h00, ra});
    endtask : nvm_read

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        summarize();
    end

    initial begin
        for (int i = 0; i < 2048; i++) mem[i] = 8'($random(seed));
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        rie = 1'b0;
        chk(nvm_control, 8'h00);
        put(1, 8'h02);
        chk(mem_req_valid | nvm_control[1], 1'b0);
        put(1, 8'hf4);
        chk(nvm_control, 8'h04);
        repeat (4) put(0, 8'h00);
        chk(nvm_control[2], 1'b0);
        put(1, 8'h02);
        chk(mem_req_valid | nvm_control[1], 1'b0);
        flash_selfprog_active = 1'b1;
        nvm_write(11'h123, 8'ha5, 1'b0);
        flash_selfprog_active = 1'b0;
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'($random(seed));
            d = 8'($random(seed));
            rie = (i == 0) ? 1'b1 : 1'($random(seed));
            gie = (i == 0) ? 1'b1 : 1'($random(seed));
            nvm_write(a, d, 1'b1);
            put(2, ~a[7:0]);
            chk(nvm_byte_address, {5'h00, a});
            put(4, ~d);
            put(1, {4'h0, rie, 3'h1});
            chk(nvm_byte_data, 8'(~d));
            chk(cpu_halt, 1'b0);
            wait_done();
            nvm_read(a, d);
        end
        d = 8'h3c;
        nvm_write(11'h2aa, d, 1'b1);
        rst = 1'b1;
        repeat (3) put(0, 8'h00);
        rst = 1'b0;
        rie = 1'b0;
        chk(nvm_control[3:1], 3'b001);
        wait_done();
        nvm_read(11'h2aa, d);
        summarize();
    end
endmodule : eac_ctrl_bench
